// ==== bench/aps_host.sv ====
// Host controller model driving the reset pin and register writes
`default_nettype none
module aps_host (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RST,
    // Device pins
    output var  logic       RESET_N_PIN,
    output var  logic       REG_WR_STB,
    output var  logic [7:0] REG_WR_ADDR,
    output var  logic [7:0] REG_WR_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        RESET_N_PIN = 1'b0;
        REG_WR_STB = 1'b0;
        REG_WR_ADDR = 8'h00;
        REG_WR_DATA = 8'h00;
        @(negedge RST);
        RESET_N_PIN = 1'b1;
    end
    // One strobed byte, then the bus shows the inverse of it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        REG_WR_STB = 1'b1;
        REG_WR_ADDR = a;
        REG_WR_DATA = d;
        @(negedge CLOCK);
        REG_WR_STB = 1'b0;
        REG_WR_ADDR = ~a;
        REG_WR_DATA = ~d;
    endtask
    task automatic pulse(input int n);
        @(negedge CLOCK);
        RESET_N_PIN = 1'b0;
        repeat (n) @(negedge CLOCK);
        RESET_N_PIN = 1'b1;
    endtask
endmodule // aps_host
`default_nettype wire

// ==== bench/aps_monitor.sv ====
// Port checker for the power-up sequencer
`default_nettype none
module aps_monitor (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RST,
    // Host writes
    input wire logic       REG_WR_STB,
    input wire logic [7:0] REG_WR_ADDR,
    // Status and drive
    input wire logic       POR_DONE,
    input wire logic       IN_RESET,
    input wire logic       CONFIGURED,
    input wire logic       WRITE_REFUSED,
    input wire logic       DRIVE_AMP_ON,
    input wire logic       SINK_EN,
    input wire logic       DRIVE_REF_INTERNAL,
    input wire logic [2:0] COMP_THRESH
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] d1_reg = 9'h000;
    logic [8:0] d2_reg = 9'h000;
    logic [8:0] d3_reg = 9'h000;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    always_ff @(posedge CLOCK) begin
        d1_reg <= {REG_WR_STB, REG_WR_ADDR};
        d2_reg <= d1_reg;
        d3_reg <= d2_reg;
    end
    // Write to offset k landed two or three edges ago
    function automatic logic hit(input logic [7:0] k);
        return d2_reg == {1'b1, k} || d3_reg == {1'b1, k};
    endfunction
    thr_source_a: assert property ($changed(COMP_THRESH) |->
        hit(8'h04) || $past(IN_RESET)) else $error("threshold moved alone");
    ref_source_a: assert property ($changed(DRIVE_REF_INTERNAL) |->
        hit(8'h0A) || $past(IN_RESET)) else $error("reference moved alone");
    amp_source_a: assert property ($changed(DRIVE_AMP_ON) |->
        hit(8'h03) || $past(IN_RESET)) else $error("amp power moved alone");
    sink_off_a: assert property (DRIVE_AMP_ON && $past(DRIVE_AMP_ON)
        |-> !SINK_EN) else $error("sink on with amplifier on");
    early_wr_a: assert property (REG_WR_STB && !POR_DONE
        |-> ##[1:2] WRITE_REFUSED) else $error("early write not refused");
    refuse_hold_a: assert property ($past(WRITE_REFUSED)
        |-> WRITE_REFUSED) else $error("refusal flag dropped");
    cfg_after_a: assert property ($rose(CONFIGURED) |-> POR_DONE &&
        (d1_reg == 9'h101 || d2_reg == 9'h101)) else $error("bad config");
endmodule // aps_monitor
bind aps_sequencer aps_monitor aps_monitor_i (
    .CLOCK(CLOCK), .RST(RST), .REG_WR_STB(REG_WR_STB),
    .REG_WR_ADDR(REG_WR_ADDR), .POR_DONE(POR_DONE), .IN_RESET(IN_RESET),
    .CONFIGURED(CONFIGURED), .WRITE_REFUSED(WRITE_REFUSED),
    .DRIVE_AMP_ON(DRIVE_AMP_ON), .SINK_EN(SINK_EN),
    .DRIVE_REF_INTERNAL(DRIVE_REF_INTERNAL), .COMP_THRESH(COMP_THRESH)
);
`default_nettype wire

// ==== bench/aps_testbench.sv ====
// Self-checking bench for the power-up sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR = 8;
    localparam int DIV = 4;
    logic CLOCK, RST, RESET_N_PIN, REG_WR_STB, POR_DONE, IN_RESET;
    logic CONFIGURED, EARLY_RESET_ERR, SHORT_RESET_ERR, WRITE_REFUSED;
    logic DRIVE_AMP_ON, DRIVE_REF_INTERNAL, DRIVE_MEASURE, SINK_EN;
    logic DRIVE_LEAD_OFF;
    logic [2:0] COMP_THRESH;
    logic [7:0] REG_WR_ADDR, REG_WR_DATA, DRIVE_OUT_LEVEL;
    logic [7:0] DRIVE_SENSE_POS, DRIVE_SENSE_NEG, LEAD_SENSE_SEL;
    logic [7:0] m [0:15];
    logic [7:0] wa [0:10] = '{8'h04, 8'h02, 8'h05, 8'h06, 8'h07, 8'h03,
        8'h0A, 8'h03, 8'h0A, 8'h03, 8'h0B};
    logic [7:0] wd [0:10] = '{8'h10, 8'hE0, 8'h0F, 8'h07, 8'h07, 8'h4C,
        8'h02, 8'h1C, 8'h00, 8'h18, 8'h55};
    int mismatches = 0;
    int samples_checked = 0;
    aps_sequencer #(.POR_WAIT_MODULATOR_PERIOD(POR), .MOD_DIV(DIV)) aps_sequencer_i (
        .CLOCK(CLOCK), .RST(RST), .RESET_N_PIN(RESET_N_PIN),
        .REG_WR_STB(REG_WR_STB), .REG_WR_ADDR(REG_WR_ADDR),
        .REG_WR_DATA(REG_WR_DATA), .DRIVE_OUT_LEVEL(DRIVE_OUT_LEVEL),
        .POR_DONE(POR_DONE), .IN_RESET(IN_RESET), .CONFIGURED(CONFIGURED),
        .EARLY_RESET_ERR(EARLY_RESET_ERR), .WRITE_REFUSED(WRITE_REFUSED),
        .SHORT_RESET_ERR(SHORT_RESET_ERR), .DRIVE_AMP_ON(DRIVE_AMP_ON),
        .DRIVE_REF_INTERNAL(DRIVE_REF_INTERNAL), .SINK_EN(SINK_EN),
        .DRIVE_MEASURE(DRIVE_MEASURE), .COMP_THRESH(COMP_THRESH),
        .DRIVE_LEAD_OFF(DRIVE_LEAD_OFF), .DRIVE_SENSE_POS(DRIVE_SENSE_POS),
        .DRIVE_SENSE_NEG(DRIVE_SENSE_NEG), .LEAD_SENSE_SEL(LEAD_SENSE_SEL)
    );
    aps_host aps_host_i (
        .CLOCK(CLOCK), .RST(RST), .RESET_N_PIN(RESET_N_PIN),
        .REG_WR_STB(REG_WR_STB), .REG_WR_ADDR(REG_WR_ADDR),
        .REG_WR_DATA(REG_WR_DATA)
    );
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %0h exp %0h", $time, seen, exp);
        end
    endtask
    // Outputs against the register model, after the two-edge latency
    task automatic cmp_all;
        int thr;
        repeat (3) @(negedge CLOCK);
        thr = (5 + 5 * m[4][7:5]) * 255 / 100;
        chk(COMP_THRESH, m[4][7:5]);
        chk(DRIVE_LEAD_OFF, m[2][6] && DRIVE_OUT_LEVEL < thr);
        chk(DRIVE_AMP_ON, m[3][2]);
        chk(SINK_EN, !m[3][2]);
        chk(DRIVE_MEASURE, m[3][4]);
        chk(DRIVE_REF_INTERNAL, m[10][1]);
        chk(LEAD_SENSE_SEL, m[5]);
        chk(DRIVE_SENSE_POS, m[6]);
        chk(DRIVE_SENSE_NEG, m[7]);
    endtask
    task automatic dflt;
        foreach (m[i]) m[i] = 8'h00;
        m[2] = 8'h80;
        m[3] = 8'h10;
        m[4] = 8'h10;
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        aps_host_i.wr(a, d);
        if (a != 8'h0B) m[a[3:0]] = d;
        cmp_all();
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end
    initial begin
        repeat (1000) @(posedge CLOCK);
        mismatches++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h92AE6279));
        RST = 1'b1;
        DRIVE_OUT_LEVEL = 8'h00;
        dflt();
        repeat (6) @(negedge CLOCK);
        RST = 1'b0;
        aps_host_i.wr(8'h04, 8'hE0);
        cmp_all();
        chk(WRITE_REFUSED, 1'b1);
        chk(CONFIGURED, 1'b0);
        $display("early write test done");
        repeat (POR * DIV) @(negedge CLOCK);
        chk(POR_DONE, 1'b1);
        aps_host_i.pulse(DIV + 1);
        repeat (2) @(negedge CLOCK);
        chk(SHORT_RESET_ERR, 1'b0);
        chk(EARLY_RESET_ERR, 1'b0);
        put(8'h01, 8'h02);
        chk(CONFIGURED, 1'b1);
        $display("power-up test done");
        foreach (wa[i]) put(wa[i], wd[i]);
        $display("configuration test done");
        repeat (6) begin
            DRIVE_OUT_LEVEL = 8'($urandom);
            put(8'h04, {3'($urandom), 5'h10});
        end
        $display("threshold test done");
        fork
            aps_host_i.pulse(2);
            begin
                repeat (2) @(negedge CLOCK);
                chk(IN_RESET, 1'b1);
            end
        join
        repeat (2) @(negedge CLOCK);
        chk(SHORT_RESET_ERR, 1'b1);
        chk(CONFIGURED, 1'b0);
        chk(IN_RESET, 1'b0);
        dflt();
        cmp_all();
        aps_host_i.pulse(DIV + 1);
        put(8'h01, 8'h02);
        chk(CONFIGURED, 1'b1);
        $display("short reset test done");
        RST = 1'b1;
        repeat (2) @(negedge CLOCK);
        RST = 1'b0;
        aps_host_i.pulse(2);
        repeat (2) @(negedge CLOCK);
        chk(EARLY_RESET_ERR, 1'b1);
        chk(POR_DONE, 1'b0);
        chk(SHORT_RESET_ERR, 1'b0);
        chk(WRITE_REFUSED, 1'b0);
        chk(CONFIGURED, 1'b0);
        cmp_all();
        $display("early reset test done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire

// ==== core/aps_map.vh ====
// Constants for the power-up and drive configuration sequencer
`ifndef APS_MAP_VH
`define APS_MAP_VH

// Clock and timing
`define APS_CLK_PERIOD_NS     50
`define APS_MOD_DIV           4
`define APS_POR_WAIT_MODULATOR_PERIOD     2048
`define APS_RST_LOW_MODULATOR_PERIOD      1
`define APS_TMR_W             16

// Register offsets
`define APS_ADDR_FIRST_CFG    8'h01
`define APS_ADDR_SECOND_CFG   8'h02
`define APS_ADDR_THIRD_CFG    8'h03
`define APS_ADDR_LEAD_OFF_CTL 8'h04
`define APS_ADDR_LEAD_SENSE   8'h05
`define APS_ADDR_DRV_SENSE_P  8'h06
`define APS_ADDR_DRV_SENSE_N  8'h07
`define APS_ADDR_MISC_TWO     8'h0A

// Reset values
`define APS_RST_FIRST_CFG     8'h02
`define APS_RST_SECOND_CFG    8'h80
`define APS_RST_THIRD_CFG     8'h10
`define APS_RST_LEAD_OFF_CTL  8'h10
`define APS_RST_ZERO          8'h00

// Field positions
`define APS_THR_MSB           7
`define APS_THR_LSB           5
`define APS_AMP_PWR_BIT       2
`define APS_MEAS_BIT          4
`define APS_REF_SRC_BIT       1
`define APS_CMP_ON_BIT        6

// Comparator threshold in percent of full scale, code 0 and step
`define APS_THR_TOP_PCT       95
`define APS_THR_STEP_PCT      5

`endif

// ==== core/aps_mod_timer.v ====
// Modulator-clock prescaler and period counter
`include "aps_map.vh"
`default_nettype none

module aps_mod_timer #(
    parameter MOD_DIV = `APS_MOD_DIV,
    parameter CNT_W   = `APS_TMR_W
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Control
    input  wire             clear,
    input  wire [CNT_W-1:0] target,
    // Status
    output reg              done_reg
);

    localparam integer DIV_LAST_I = MOD_DIV - 1;
    localparam [7:0]   DIV_LAST   = DIV_LAST_I[7:0];

    reg [7:0]       pre_reg;
    reg [CNT_W-1:0] cnt_reg;
    wire            tick = (pre_reg == DIV_LAST);

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_reg  <= 8'h00;
            cnt_reg  <= {CNT_W{1'b0}};
            done_reg <= 1'b0;
        end else if (clear) begin
            pre_reg  <= 8'h00;
            cnt_reg  <= {CNT_W{1'b0}};
            done_reg <= 1'b0;
        end else begin
            pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
            if (tick && !done_reg) begin
                cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                // Whole modulator periods only; done when target reached
                if (cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1} >= target)
                    done_reg <= 1'b1;
            end
        end
    end

endmodule // aps_mod_timer

`default_nettype wire

// ==== core/aps_sequencer.v ====
// Power-up sequence watcher and drive amplifier configuration
`include "aps_map.vh"
`default_nettype none

module aps_sequencer #(
    parameter POR_WAIT_MODULATOR_PERIOD = `APS_POR_WAIT_MODULATOR_PERIOD,
    parameter MOD_DIV       = `APS_MOD_DIV
) (
    // Clock and reset
    input  wire       CLOCK,
    input  wire       RST,
    // Host pins
    input  wire       RESET_N_PIN,
    input  wire       REG_WR_STB,
    input  wire [7:0] REG_WR_ADDR,
    input  wire [7:0] REG_WR_DATA,
    // Digitised drive amplifier output
    input  wire [7:0] DRIVE_OUT_LEVEL,
    // Sequence status
    output reg        POR_DONE,
    output reg        IN_RESET,
    output reg        CONFIGURED,
    output reg        EARLY_RESET_ERR,
    output reg        SHORT_RESET_ERR,
    output reg        WRITE_REFUSED,
    // Drive control and lead-off
    output reg        DRIVE_AMP_ON,
    output reg        DRIVE_REF_INTERNAL,
    output reg        DRIVE_MEASURE,
    output reg        SINK_EN,
    output reg  [2:0] COMP_THRESH,
    output reg        DRIVE_LEAD_OFF,
    output reg  [7:0] DRIVE_SENSE_POS,
    output reg  [7:0] DRIVE_SENSE_NEG,
    output reg  [7:0] LEAD_SENSE_SEL
);

    localparam [2:0] ST_POR    = 3'h0;
    localparam [2:0] ST_ARMED  = 3'h1;
    localparam [2:0] ST_RESET  = 3'h2;
    localparam [2:0] ST_CONFIG = 3'h3;
    localparam [2:0] ST_RUN    = 3'h4;

    localparam integer POR_TGT_I = POR_WAIT_MODULATOR_PERIOD;
    localparam [15:0]  POR_TGT   = POR_TGT_I[15:0];
    localparam [15:0] RST_TGT = `APS_RST_LOW_MODULATOR_PERIOD;

    // Low comparator level, negative side, 8-bit full scale
    // Product kept at 32 bits so the full-scale scaling cannot wrap
    function [7:0] low_level;
        input [2:0] code;
        reg   [31:0] prod;
        begin
            prod = (32'h0000_0064 - `APS_THR_TOP_PCT
                   + {29'h0000_0000, code} * `APS_THR_STEP_PCT)
                   * 32'h0000_00FF / 32'h0000_0064;
            low_level = prod[7:0];
        end
    endfunction

    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg  [7:0] first_cfg_reg;
    reg  [7:0] second_cfg_reg;
    reg  [7:0] third_cfg_reg;
    reg  [7:0] lead_off_control_reg;
    reg  [7:0] misc_two_reg;
    wire       tmr_done;
    wire       tmr_clear;
    wire       wr_ok;
    wire [7:0] thr_low;

    ////////////////////////////////////////////////////////////////////
    // Modulator period timer, restarted on every state change

    assign tmr_clear = (state_next != state_reg);

    aps_mod_timer #(
        .MOD_DIV (MOD_DIV),
        .CNT_W   (`APS_TMR_W)
    ) u_timer (
        .clk      (CLOCK),
        .rst      (RST),
        .clear    (tmr_clear),
        .target   ((state_reg == ST_RESET) ? RST_TGT : POR_TGT),
        .done_reg (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequence states

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_POR: begin
                if (tmr_done)
                    state_next = ST_ARMED;
            end
            ST_ARMED: begin
                if (!RESET_N_PIN)
                    state_next = ST_RESET;
            end
            ST_RESET: begin
                if (RESET_N_PIN)
                    state_next = tmr_done ? ST_CONFIG : ST_ARMED;
            end
            ST_CONFIG: begin
                if (!RESET_N_PIN)
                    state_next = ST_RESET;
                else if (REG_WR_STB &&
                         REG_WR_ADDR == `APS_ADDR_FIRST_CFG)
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (!RESET_N_PIN)
                    state_next = ST_RESET;
            end
            default: state_next = ST_POR;
        endcase
    end

    // Writes are only taken once the wait and pulse are over
    assign wr_ok = REG_WR_STB && RESET_N_PIN &&
                   (state_reg == ST_CONFIG || state_reg == ST_RUN);

    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_reg       <= ST_POR;
            POR_DONE        <= 1'b0;
            IN_RESET        <= 1'b0;
            CONFIGURED      <= 1'b0;
            EARLY_RESET_ERR <= 1'b0;
            SHORT_RESET_ERR <= 1'b0;
            WRITE_REFUSED   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            POR_DONE   <= (state_next != ST_POR);
            IN_RESET   <= (state_next == ST_RESET);
            CONFIGURED <= (state_next == ST_RUN);
            if (state_reg == ST_POR && !RESET_N_PIN)
                EARLY_RESET_ERR <= 1'b1;
            if (state_reg == ST_RESET && RESET_N_PIN && !tmr_done)
                SHORT_RESET_ERR <= 1'b1;
            if (REG_WR_STB && !wr_ok)
                WRITE_REFUSED <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers, defaults restored by the reset pulse

    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            first_cfg_reg        <= `APS_RST_FIRST_CFG;
            second_cfg_reg       <= `APS_RST_SECOND_CFG;
            third_cfg_reg        <= `APS_RST_THIRD_CFG;
            lead_off_control_reg <= `APS_RST_LEAD_OFF_CTL;
            misc_two_reg         <= `APS_RST_ZERO;
            LEAD_SENSE_SEL       <= `APS_RST_ZERO;
            DRIVE_SENSE_POS      <= `APS_RST_ZERO;
            DRIVE_SENSE_NEG      <= `APS_RST_ZERO;
        end else if (state_reg == ST_RESET) begin
            first_cfg_reg        <= `APS_RST_FIRST_CFG;
            second_cfg_reg       <= `APS_RST_SECOND_CFG;
            third_cfg_reg        <= `APS_RST_THIRD_CFG;
            lead_off_control_reg <= `APS_RST_LEAD_OFF_CTL;
            misc_two_reg         <= `APS_RST_ZERO;
            LEAD_SENSE_SEL       <= `APS_RST_ZERO;
            DRIVE_SENSE_POS      <= `APS_RST_ZERO;
            DRIVE_SENSE_NEG      <= `APS_RST_ZERO;
        end else if (wr_ok) begin
            case (REG_WR_ADDR)
                `APS_ADDR_FIRST_CFG:    first_cfg_reg <= REG_WR_DATA;
                `APS_ADDR_SECOND_CFG:   second_cfg_reg <= REG_WR_DATA;
                `APS_ADDR_THIRD_CFG:    third_cfg_reg <= REG_WR_DATA;
                `APS_ADDR_LEAD_OFF_CTL:
                    lead_off_control_reg <= REG_WR_DATA;
                `APS_ADDR_LEAD_SENSE:   LEAD_SENSE_SEL <= REG_WR_DATA;
                `APS_ADDR_DRV_SENSE_P:  DRIVE_SENSE_POS <= REG_WR_DATA;
                `APS_ADDR_DRV_SENSE_N:  DRIVE_SENSE_NEG <= REG_WR_DATA;
                `APS_ADDR_MISC_TWO:     misc_two_reg <= REG_WR_DATA;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Drive amplifier, reference and electrode check

    assign thr_low = low_level(
        lead_off_control_reg[`APS_THR_MSB:`APS_THR_LSB]);

    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            DRIVE_AMP_ON       <= 1'b0;
            DRIVE_REF_INTERNAL <= 1'b0;
            DRIVE_MEASURE      <= 1'b0;
            SINK_EN            <= 1'b0;
            COMP_THRESH        <= 3'h0;
            DRIVE_LEAD_OFF     <= 1'b0;
        end else begin
            DRIVE_AMP_ON  <= third_cfg_reg[`APS_AMP_PWR_BIT];
            DRIVE_MEASURE <= third_cfg_reg[`APS_MEAS_BIT];
            DRIVE_REF_INTERNAL <=
                misc_two_reg[`APS_REF_SRC_BIT];
            // Sink only excites while the amplifier is off
            SINK_EN <= !third_cfg_reg[`APS_AMP_PWR_BIT]
                       && (state_reg != ST_RESET);
            COMP_THRESH <=
                lead_off_control_reg[`APS_THR_MSB:`APS_THR_LSB];
            // Comparator on amplifier output, same low threshold
            DRIVE_LEAD_OFF <= second_cfg_reg[`APS_CMP_ON_BIT] &&
                              (DRIVE_OUT_LEVEL < thr_low);
        end
    end

endmodule // aps_sequencer

`default_nettype wire
